/* tdb_buzzer_model.sv */
`timescale 1ns/100ps
module tdb_buzzer_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Drive from the buzzer pin
    input wire logic bz_true,
    // Pulse counter
    input wire logic clear,
    output int unsigned pulse_count
);
    logic last;

    // Counts drive pulses reaching the transistor base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            pulse_count <= 0;
        end else begin
            last <= bz_true;
            if (clear) begin
                pulse_count <= 0;
            end else if (bz_true && !last) begin
                pulse_count <= pulse_count + 1;
            end
        end
    end
endmodule : tdb_buzzer_model

/* tdb_pkg.sv */
// Overview of operation
// RL1 - Output frequency is source over (N+1) times X
// RL2 - Preset write starts output with new settings
// RL3 - Source select write picks the divider input
// RL4 - Register form: accumulator high nibble, memory low
// RL5 - Indirect form: all eight bits from table
// RL6 - Immediate form: all eight bits from operand
// RL7 - Duty code 00,01,10,11 gives 1/4,1/3,1/2,1/1; code 11 here gives one source event high per period
// RL8 - Divider output feeds alarm, timers and counter
// RL9 - Inverted buzzer pin is inverse of true pin; the code holds both pins low while the buzzer config is all zero
// RL10 - Buzzer pins share port B bits three, four
// RL11 - Carrier is divider output or tap three/four/five
// RL12 - Only one carrier source active at once
// RL13 - Envelope is any mix of taps ten to fifteen
// RL14 - Any subset of envelope taps, including all
// RL15 - Buzzer config write loads carrier and envelope
// RL16 - Both buzzer pins low after reset until configured
// RL17 - Software keeps scaling value at least three for carrier
// RL18 - Software writes buzzer config right after preset
// RL19 - All-zero buzzer config stops the buzzer output
// RL20 - Reset: base tap source, quarter duty, output inactive
// RL21 - True pin is carrier AND OR of envelope taps; with no envelope tap set the code passes the carrier alone
// RL22 - Config holds carrier field and six envelope bits
// RL23 - New preset reloads at terminal count, no glitch
package tdb_pkg;

    localparam int unsigned TDB_CLK_HZ = 200_000_000;
    localparam int unsigned TDB_ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] TDB_SRC_OFS = 8'h00;
    localparam logic [7:0] TDB_PRESET_OFS = 8'h04;
    localparam logic [7:0] TDB_BUZZ_OFS = 8'h08;
    localparam logic [7:0] TDB_STATUS_OFS = 8'h0C;

    // Preset register fields
    localparam int unsigned TDB_PR_N_LSB = 0;
    localparam int unsigned TDB_PR_DUTY_LSB = 8;
    localparam int unsigned TDB_PR_FORM_LSB = 10;

    // Buzzer config fields
    localparam int unsigned TDB_BZ_CAR_LSB = 0;
    localparam int unsigned TDB_BZ_ENV_LSB = 3;
    localparam int unsigned TDB_ENV_W = 6;

    // Prescaler layout
    localparam int unsigned TDB_PRESC_W = 15;
    localparam int unsigned TDB_TAP_CAR_LO = 3;
    localparam int unsigned TDB_TAP_ENV_LO = 10;

    localparam logic [7:0] TDB_N_RESET = 8'h00;
    localparam logic [7:0] TDB_CNT_ZERO = 8'h00;

    typedef enum logic [1:0] {
        TDB_SRC_BASE,
        TDB_SRC_SYSCLK,
        TDB_SRC_TAP1,
        TDB_SRC_TAP2
    } tdb_src_e;

    typedef enum logic [1:0] {
        TDB_DUTY_QUARTER,
        TDB_DUTY_THIRD,
        TDB_DUTY_HALF,
        TDB_DUTY_FULL
    } tdb_duty_e;

    typedef enum logic [1:0] {
        TDB_FORM_REG,
        TDB_FORM_TABLE,
        TDB_FORM_IMM,
        TDB_FORM_RSVD
    } tdb_form_e;

    typedef enum logic [2:0] {
        TDB_CAR_NONE,
        TDB_CAR_DIV,
        TDB_CAR_TAP3,
        TDB_CAR_TAP4,
        TDB_CAR_TAP5
    } tdb_car_e;

    typedef struct packed {
        logic [7:0] n;
        tdb_duty_e duty;
    } tdb_preset_s;

    typedef struct packed {
        tdb_car_e carrier;
        logic [5:0] env;
    } tdb_buzz_s;

    localparam tdb_preset_s TDB_PRESET_RESET = '{n: 8'h00, duty: TDB_DUTY_QUARTER};
    localparam tdb_buzz_s TDB_BUZZ_RESET = '{carrier: TDB_CAR_NONE, env: 6'h00};

endpackage : tdb_pkg

/* tdb_tone_divider.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
module tdb_tone_divider
    import tdb_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TDB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Preset operand sources
    input wire logic [3:0] accumulator_reg,
    input wire logic [3:0] data_mem_word,
    input wire logic [7:0] table_rom_word,
    // Prescaler base enable pulse
    input wire logic prescaler_base_tap,
    // Divider output to consumers
    output logic divider_output,
    output logic divider_output_rise,
    // Pad function straps, high selects buzzer
    input wire logic strap_pad3_buzzer,
    input wire logic strap_pad4_buzzer,
    // Port B general purpose data for the shared pads
    input wire logic port_b_bit_three,
    input wire logic port_b_bit_four,
    input wire logic port_b_oe_three,
    input wire logic port_b_oe_four,
    // Buzzer pins and shared pads
    output logic buzzer_true_out,
    output logic buzzer_inverted_out,
    output logic pad3_out,
    output logic pad3_oe,
    output logic pad4_out,
    output logic pad4_oe
);

    tdb_src_e src_sel;
    tdb_preset_s cur_preset;
    tdb_preset_s pend_preset;
    tdb_buzz_s buzz_cfg;
    logic div_active;
    logic [7:0] div_cnt;
    logic [1:0] div_phase;
    logic [1:0] last_phase;
    logic [TDB_PRESC_W-1:0] presc;
    logic [TDB_PRESC_W:0] taps;
    logic tap1_q;
    logic tap2_q;
    logic src_evt;
    logic terminal;
    logic period_end;
    logic next_div_out;
    logic next_true;
    logic carrier_level;
    logic env_ok;
    logic [TDB_ENV_W-1:0] env_hit;
    logic buzz_on;
    logic strap_taken;
    logic pad3_bz;
    logic pad4_bz;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    tdb_preset_s next_pend;

    // Bus decode
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        if (paddr == TDB_SRC_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == TDB_PRESET_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == TDB_BUZZ_OFS) begin
            addr_ok = 1'b1;
        end else if (paddr == TDB_STATUS_OFS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            if (paddr == TDB_SRC_OFS) begin
                prdata <= {30'h0000_0000, src_sel};
            end else if (paddr == TDB_PRESET_OFS) begin
                prdata <= {22'h00_0000, pend_preset};
            end else if (paddr == TDB_BUZZ_OFS) begin
                prdata <= {23'h00_0000, buzz_cfg};
            end else if (paddr == TDB_STATUS_OFS) begin
                prdata <= {16'h0000, cur_preset.n, buzzer_true_out, divider_output,
                    div_phase, cur_preset.duty, div_active, 1'b0};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Source select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel <= TDB_SRC_BASE; // see RL20
        end else if (wr_en && paddr == TDB_SRC_OFS) begin
            src_sel <= tdb_src_e'(pwdata[1:0]); // see RL3
        end
    end

    // Preset operand assembly
    always_comb begin
        next_pend.duty = tdb_duty_e'(pwdata[TDB_PR_DUTY_LSB +: 2]); // see RL7
        case (tdb_form_e'(pwdata[TDB_PR_FORM_LSB +: 2]))
            TDB_FORM_REG: begin
                next_pend.n = {accumulator_reg, data_mem_word}; // see RL4
            end
            TDB_FORM_TABLE: begin
                next_pend.n = table_rom_word; // see RL5
            end
            default: begin
                next_pend.n = pwdata[TDB_PR_N_LSB +: 8]; // see RL6
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_preset <= TDB_PRESET_RESET;
        end else if (wr_en && paddr == TDB_PRESET_OFS) begin
            pend_preset <= next_pend;
        end
    end

    // Prescaler chain, tap k is stage k of the divide-by-two chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
        end else if (prescaler_base_tap) begin
            presc <= presc + 1'b1;
        end
    end

    assign taps = {presc, prescaler_base_tap};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap1_q <= 1'b0;
            tap2_q <= 1'b0;
        end else begin
            tap1_q <= taps[1];
            tap2_q <= taps[2];
        end
    end

    always_comb begin
        case (src_sel)
            TDB_SRC_BASE: src_evt = prescaler_base_tap;
            TDB_SRC_SYSCLK: src_evt = 1'b1;
            TDB_SRC_TAP1: src_evt = taps[1] && !tap1_q;
            default: src_evt = taps[2] && !tap2_q;
        endcase
    end

    // Divider: N+1 source events per phase, X phases per period
    always_comb begin
        case (cur_preset.duty)
            TDB_DUTY_QUARTER: last_phase = 2'd3; // see RL7
            TDB_DUTY_THIRD: last_phase = 2'd2;
            TDB_DUTY_HALF: last_phase = 2'd1;
            default: last_phase = 2'd0;
        endcase
    end

    assign terminal = div_active && src_evt && div_cnt == cur_preset.n;
    assign period_end = terminal && div_phase == last_phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_active <= 1'b0; // see RL20
            cur_preset <= TDB_PRESET_RESET;
            div_cnt <= TDB_CNT_ZERO;
            div_phase <= 2'd0;
        end else if (!div_active && wr_en && paddr == TDB_PRESET_OFS) begin
            div_active <= 1'b1; // see RL2
            cur_preset <= next_pend;
            div_cnt <= TDB_CNT_ZERO;
            div_phase <= 2'd0;
        end else if (period_end) begin
            cur_preset <= pend_preset; // see RL23
            div_cnt <= TDB_CNT_ZERO;
            div_phase <= 2'd0;
        end else if (terminal) begin
            div_cnt <= TDB_CNT_ZERO; // see RL1
            div_phase <= div_phase + 2'd1;
        end else if (div_active && src_evt) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // High for the first phase; full duty gives one source event high
    assign next_div_out = div_active && div_phase == 2'd0
        && (cur_preset.duty != TDB_DUTY_FULL || div_cnt == TDB_CNT_ZERO);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_output <= 1'b0;
            divider_output_rise <= 1'b0;
        end else begin
            divider_output <= next_div_out; // see RL8
            divider_output_rise <= next_div_out && !divider_output;
        end
    end

    // Buzzer configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzz_cfg <= TDB_BUZZ_RESET; // see RL16
        end else if (wr_en && paddr == TDB_BUZZ_OFS) begin
            buzz_cfg.carrier <= tdb_car_e'(pwdata[TDB_BZ_CAR_LSB +: 3]); // see RL15, RL22
            buzz_cfg.env <= pwdata[TDB_BZ_ENV_LSB +: TDB_ENV_W]; // see RL14
        end
    end

    // Single carrier chosen by one field
    always_comb begin
        case (buzz_cfg.carrier)
            TDB_CAR_DIV: carrier_level = divider_output; // see RL12
            TDB_CAR_TAP3: carrier_level = taps[TDB_TAP_CAR_LO]; // see RL11
            TDB_CAR_TAP4: carrier_level = taps[TDB_TAP_CAR_LO + 1];
            TDB_CAR_TAP5: carrier_level = taps[TDB_TAP_CAR_LO + 2];
            default: carrier_level = 1'b0;
        endcase
    end

    // Envelope taps ten to fifteen
    genvar gi;
    generate
        for (gi = 0; gi < TDB_ENV_W; gi++) begin : g_env
            assign env_hit[gi] = buzz_cfg.env[gi] && taps[TDB_TAP_ENV_LO + gi]; // see RL13
        end
    endgenerate

    assign env_ok = (buzz_cfg.env == '0) || (|env_hit); // see RL21
    assign buzz_on = buzz_cfg != TDB_BUZZ_RESET; // see RL19
    assign next_true = buzz_on && carrier_level && env_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buzzer_true_out <= 1'b0; // see RL16
            buzzer_inverted_out <= 1'b0;
        end else if (!buzz_on) begin
            buzzer_true_out <= 1'b0; // see RL19
            buzzer_inverted_out <= 1'b0;
        end else begin
            buzzer_true_out <= next_true; // see RL21
            buzzer_inverted_out <= !next_true; // see RL9
        end
    end

    // Pad function straps caught after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken <= 1'b0;
            pad3_bz <= 1'b0;
            pad4_bz <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            pad3_bz <= strap_pad3_buzzer; // see RL10
            pad4_bz <= strap_pad4_buzzer;
        end
    end

    assign pad3_out = pad3_bz ? buzzer_inverted_out : port_b_bit_three; // see RL10
    assign pad3_oe = pad3_bz ? strap_taken : port_b_oe_three;
    assign pad4_out = pad4_bz ? buzzer_true_out : port_b_bit_four;
    assign pad4_oe = pad4_bz ? strap_taken : port_b_oe_four;

    // Assertions
    complementary_pins_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
        $past(buzz_on) && buzz_on |-> buzzer_inverted_out == !buzzer_true_out)
        else $error("buzzer pins not complementary");

    stopped_low_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL19
        !buzz_on |=> !buzzer_true_out && !buzzer_inverted_out)
        else $error("buzzer pins not low while stopped");

    inactive_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL20
        !div_active |=> !divider_output)
        else $error("divider output while inactive");

    reload_end_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL23
        period_end && !(wr_en && paddr == TDB_PRESET_OFS) |=> cur_preset == $past(pend_preset))
        else $error("preset not reloaded at period end");

    count_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
        div_active |-> div_cnt <= cur_preset.n && div_phase <= last_phase)
        else $error("divider count out of range");

    imm_load_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
        wr_en && paddr == TDB_PRESET_OFS && pwdata[TDB_PR_FORM_LSB +: 2] == 2'd2
        |=> pend_preset.n == $past(pwdata[7:0]))
        else $error("immediate preset not loaded");

    reg_load_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL4
        wr_en && paddr == TDB_PRESET_OFS && pwdata[TDB_PR_FORM_LSB +: 2] == 2'd0
        |=> pend_preset.n == {$past(accumulator_reg), $past(data_mem_word)})
        else $error("register preset not loaded");

    table_load_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL5
        wr_en && paddr == TDB_PRESET_OFS && pwdata[TDB_PR_FORM_LSB +: 2] == 2'd1
        |=> pend_preset.n == $past(table_rom_word))
        else $error("table preset not loaded");

    start_out_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL2
        !div_active && wr_en && paddr == TDB_PRESET_OFS |=> div_active ##1 divider_output)
        else $error("divider did not start after preset");

    envelope_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL13
        buzz_cfg.env != '0 && env_hit == '0 |=> !buzzer_true_out)
        else $error("envelope did not gate carrier");

    tap3_carrier_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
        buzz_cfg.carrier == TDB_CAR_TAP3 && buzz_cfg.env == '0
        |=> buzzer_true_out == $past(taps[TDB_TAP_CAR_LO]))
        else $error("tap three carrier not passed");

    cover_reload_c: cover property (@(posedge pclk) disable iff (!presetn)
        period_end && pend_preset != cur_preset);
    cover_buzz_div_c: cover property (@(posedge pclk) disable iff (!presetn)
        buzz_cfg.carrier == TDB_CAR_DIV && buzzer_true_out);
    cover_env_all_c: cover property (@(posedge pclk) disable iff (!presetn)
        buzz_cfg.env == 6'h3F && buzzer_true_out);
    cover_full_duty_c: cover property (@(posedge pclk) disable iff (!presetn)
        cur_preset.duty == TDB_DUTY_FULL && divider_output_rise);

endmodule : tdb_tone_divider

/* tone_divider_and_buzzer_modulator_tb.sv */
`timescale 1ns/100ps
module tone_divider_and_buzzer_modulator_tb
    import tdb_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] accumulator_reg, data_mem_word;
    logic [7:0] table_rom_word;
    logic prescaler_base_tap, divider_output, divider_output_rise;
    logic strap_pad3_buzzer, strap_pad4_buzzer;
    logic port_b_bit_three, port_b_bit_four, port_b_oe_three, port_b_oe_four;
    logic buzzer_true_out, buzzer_inverted_out, pad3_out, pad3_oe, pad4_out, pad4_oe;
    logic e, clr, buzz_on, prev_div;
    int err_count, n_checks, cyc, per, hi;
    int unsigned bz_count;
    int per_src[4] = '{8, 4, 16, 32};
    logic [7:0] exp_n[4] = '{8'hA5, 8'h3C, 8'h21, 8'h21};

    tdb_tone_divider u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accumulator_reg(accumulator_reg), .data_mem_word(data_mem_word),
        .table_rom_word(table_rom_word), .prescaler_base_tap(prescaler_base_tap),
        .divider_output(divider_output), .divider_output_rise(divider_output_rise),
        .strap_pad3_buzzer(strap_pad3_buzzer), .strap_pad4_buzzer(strap_pad4_buzzer),
        .port_b_bit_three(port_b_bit_three), .port_b_bit_four(port_b_bit_four),
        .port_b_oe_three(port_b_oe_three), .port_b_oe_four(port_b_oe_four),
        .buzzer_true_out(buzzer_true_out), .buzzer_inverted_out(buzzer_inverted_out),
        .pad3_out(pad3_out), .pad3_oe(pad3_oe), .pad4_out(pad4_out), .pad4_oe(pad4_oe));

    tdb_buzzer_model u_buzzer (.pclk(pclk), .presetn(presetn), .bz_true(buzzer_true_out),
        .clear(clr), .pulse_count(bz_count));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {accumulator_reg, data_mem_word, table_rom_word, prescaler_base_tap} = '0;
        {strap_pad3_buzzer, strap_pad4_buzzer} = 2'b10;
        {port_b_bit_three, port_b_bit_four, port_b_oe_three, port_b_oe_four} = 4'b1101;
        {clr, buzz_on, prev_div, err_count, n_checks, cyc} = '0;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        prescaler_base_tap <= ~prescaler_base_tap;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge pclk) begin
        prev_div <= divider_output;
        if (presetn) begin
            check(divider_output_rise, {divider_output & ~prev_div});
            if (buzz_on) check(buzzer_inverted_out, {~buzzer_true_out});
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic preset(input logic [1:0] form, input logic [1:0] duty, input logic [7:0] n);
        apb(1'b1, TDB_PRESET_OFS, (32'(form) << TDB_PR_FORM_LSB) |
            (32'(duty) << TDB_PR_DUTY_LSB) | (32'(n) << TDB_PR_N_LSB));
    endtask : preset

    task automatic buzz(input logic [2:0] car, input logic [5:0] env);
        apb(1'b1, TDB_BUZZ_OFS, (32'(car) << TDB_BZ_CAR_LSB) | (32'(env) << TDB_BZ_ENV_LSB));
    endtask : buzz

    function automatic logic pick(input int s);
        return (s == 1) ? buzzer_true_out : divider_output;
    endfunction : pick

    task automatic wait_lvl(input int s, input logic v);
        while (pick(s) !== v) @(posedge pclk);
    endtask : wait_lvl

    task automatic measure(input int s);
        int t0;
        wait_lvl(s, 1'b0);
        wait_lvl(s, 1'b1);
        t0 = cyc;
        wait_lvl(s, 1'b0);
        hi = cyc - t0;
        wait_lvl(s, 1'b1);
        per = cyc - t0;
    endtask : measure

    task automatic count_win(input int c);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (c) @(posedge pclk);
    endtask : count_win

    task automatic rst();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, TDB_STATUS_OFS, 32'h0000_0000);
        check(q, 32'h0000_0000);
        apb(1'b0, TDB_SRC_OFS, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check({buzzer_true_out, buzzer_inverted_out}, 2'b00);
    endtask : rst

    initial begin
        int t0;
        rst();
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        check(e, 1'b1);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check(e, 1'b1);
        check(q, 32'h0000_0000);
        apb(1'b1, TDB_SRC_OFS, 32'h0000_0001);
        preset(2'd2, TDB_DUTY_HALF, 8'h03);
        repeat (2) @(posedge pclk);
        check(divider_output, 1'b1);
        for (int d = 0; d < 4; d++) begin
            preset(2'd2, 2'(d), 8'h03);
            measure(0);
            measure(0);
            check(per, 4 * (4 - d));
            check(hi, (d == 3) ? 1 : 4);
        end
        preset(2'd2, TDB_DUTY_HALF, 8'h07);
        measure(0);
        measure(0);
        t0 = cyc;
        preset(2'd2, TDB_DUTY_HALF, 8'h01);
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        check(cyc - t0, 16);
        measure(0);
        check(per, 4);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, TDB_SRC_OFS, 32'(s));
            measure(0);
            measure(0);
            check(per, per_src[s]);
        end
        apb(1'b1, TDB_SRC_OFS, 32'h0000_0001);
        accumulator_reg <= 4'hA;
        data_mem_word <= 4'h5;
        table_rom_word <= 8'h3C;
        for (int f = 0; f < 4; f++) begin
            preset(2'(f), TDB_DUTY_FULL, 8'h21);
            apb(1'b0, TDB_PRESET_OFS, 32'h0000_0000);
            check(q, {22'h0, exp_n[f], 2'b11});
        end
        repeat (300) @(posedge pclk);
        apb(1'b0, TDB_STATUS_OFS, 32'h0000_0000);
        check({q[15:8], q[3:1]}, {8'h21, 3'b111});
        preset(2'd2, TDB_DUTY_HALF, 8'h03);
        buzz(TDB_CAR_DIV, 6'h00);
        repeat (3) @(posedge pclk);
        buzz_on = 1'b1;
        measure(1);
        measure(1);
        check(per, 8);
        check(hi, 4);
        check({pad3_out, pad3_oe, pad4_out, pad4_oe},
            {buzzer_inverted_out, 1'b1, port_b_bit_four, port_b_oe_four});
        for (int c = 0; c < 3; c++) begin
            buzz(3'(2 + c), 6'h00);
            measure(1);
            measure(1);
            check(per, 16 << c);
        end
        buzz_on = 1'b0;
        buzz(3'd5, 6'h00);
        repeat (2) @(posedge pclk);
        count_win(200);
        check(bz_count, 0);
        buzz(TDB_CAR_TAP3, 6'h01);
        repeat (3) @(posedge pclk);
        buzz_on = 1'b1;
        count_win(4096);
        check(bz_count inside {[126:130]}, 1'b1);
        buzz(TDB_CAR_TAP3, 6'h3F);
        count_win(4096);
        check(bz_count >= 190, 1'b1);
        buzz_on = 1'b0;
        buzz(TDB_CAR_NONE, 6'h00);
        repeat (2) @(posedge pclk);
        count_win(100);
        check(bz_count, 0);
        check({buzzer_true_out, buzzer_inverted_out}, 2'b00);
        strap_pad3_buzzer <= 1'b0;
        strap_pad4_buzzer <= 1'b1;
        rst();
        check({pad4_out, pad4_oe, pad3_out, pad3_oe},
            {buzzer_true_out, 1'b1, port_b_bit_three, port_b_oe_three});
        finish_test();
    end

    initial begin
        repeat (80000) @(posedge pclk);
        err_count++;
        finish_test();
    end
endmodule : tone_divider_and_buzzer_modulator_tb
